// file: hdl/flash_guard_map.svh
// Constant map of the serial flash guard block
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH

`define FLC_CORE_CLK_MHZ 10
`define FLC_PUW_TIME_US 10
`define FLC_STATUS_STORE_CMD_TIME_US 50
`define FLC_PP_TIME_US 100
`define FLC_SE_TIME_US 500
`define FLC_BE_TIME_US 1000

`define FLC_OP_MODIFY_PERMIT_SET_CMD 8'h06
`define FLC_OP_MODIFY_PERMIT_CLEAR_CMD 8'h04
`define FLC_OP_RDSR 8'h05
`define FLC_OP_STATUS_STORE_CMD 8'h01
`define FLC_OP_PP 8'h02
`define FLC_OP_SE 8'hd8
`define FLC_OP_BE 8'hc7
`define FLC_OP_DP 8'hb9
`define FLC_OP_RES 8'hab

`define FLC_BIT_LAST 3'h7
`define FLC_BIT_ZERO 3'h0
`define FLC_BYTE_MAX 3'h7
`define FLC_LEN_ONE 3'h1
`define FLC_LEN_STATUS_STORE_CMD 3'h2
`define FLC_LEN_SE 3'h4
`define FLC_LEN_PP 3'h5
`define FLC_RES_DUMMY_LAST 3'h3

`define FLC_ST_BUSY 0
`define FLC_ST_WEL 1
`define FLC_ST_BP0 2
`define FLC_ST_BP1 3
`define FLC_ST_LOCK 7
`define FLC_BP_NONE 2'h0
`define FLC_BP_ALL 2'h3
`define FLC_NV_BP_RST 2'h0
`define FLC_NV_LOCK_RST 1'h0

`define FLC_SYNC_RST 5'h1c
`define FLC_SIGNATURE 8'h5a

`endif

// file: hdl/flash_guard_pkg.sv
// Types shared by the serial flash guard block
package flash_guard_pkg;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_STANDBY, PWR_DEEP} power_mode_e;
  typedef enum logic [2:0] {OP_NONE, OP_STATUS, OP_PAGE, OP_SECTOR, OP_FULL} op_kind_e;
  typedef logic [7:0] byte_t;
endpackage : flash_guard_pkg

// file: hdl/pin_sync.sv
// Two flip-flop synchroniser bank for pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int           WIDTH   = 1,
  parameter [WIDTH-1:0]   RST_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_ff;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("pin_sync width must be at least one");
    end
  endgenerate

  // First stage is read only by the second stage
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff      <= RST_VAL;
      pin_sync_out <= RST_VAL;
    end
    else
    begin
      meta_ff      <= pin_in;
      pin_sync_out <= meta_ff;
    end
  end
endmodule : pin_sync

// file: hdl/flash_guard_ctl.sv
// Power mode, status, protection and hold control of a small serial flash
// Overview of operation
// (R1) Select low means selected and active power mode.
// (R2) Deselected: stay active until internal cycle ends, then standby.
// (R3) Deep power-down entered only by the deep sleep instruction.
// (R4) Deep power-down left only by the wake and signature instruction.
// (R5) In deep power-down ignore status store, page write and wipe.
// (R6) Busy flag set during status store, program or erase cycle.
// (R7) A status bit mirrors the modify permit latch.
// (R8) Two non-volatile block guard bits choose the shielded array area.
// (R9) Lock bit with protect pin low makes guard and lock bits read-only.
// (R10) Modifying instructions need a clock count that is a multiple of eight.
// (R11) Modifying instructions refused unless the permit latch is set.
// (R12) Permit latch cleared at power-up and after clear, store, write, wipe.
// (R13) Power-on delay timer blocks modifying operations after power-up.
// (R14) Guard bits 00 protect nothing, 11 protect both sectors.
// (R15) Guard bits 01 or 10 allow page write and sector wipe, refuse full wipe.
// (R16) Full wipe accepted only with both guard bits zero.
// (R17) Hold pauses the link without losing bit count or aborting cycles.
// (R18) Hold honoured only while selected.
// (R19) Hold begins at hold fall with clock low, else next clock low.
// (R20) Hold ends at hold rise with clock low, else next clock low.
// (R21) While held, output floats and data and clock inputs are ignored.
// (R22) Deselect during hold resets the interface; master raises hold first.
// (R23) Inputs captured on rising clock edges, output changes after falling.
// (R24) A select falling edge after power-up is needed before any instruction.
// (R25) Master keeps select low during the whole hold interval.
`timescale 1ns/1ns
`include "flash_guard_map.svh"
module flash_guard_ctl
  import flash_guard_pkg::*;
#(
  parameter int PUW_CYC  = `FLC_PUW_TIME_US * `FLC_CORE_CLK_MHZ,
  parameter int STATUS_STORE_CMD_CYC = `FLC_STATUS_STORE_CMD_TIME_US * `FLC_CORE_CLK_MHZ,
  parameter int PP_CYC   = `FLC_PP_TIME_US * `FLC_CORE_CLK_MHZ,
  parameter int SE_CYC   = `FLC_SE_TIME_US * `FLC_CORE_CLK_MHZ,
  parameter int BE_CYC   = `FLC_BE_TIME_US * `FLC_CORE_CLK_MHZ,
  parameter int CNT_W    = 24
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   sclk_pin,
  input  wire logic                   cs_n_pin,
  input  wire logic                   mosi_pin,
  input  wire logic                   hold_n_pin,
  input  wire logic                   wp_n_pin,
  output logic                        miso,
  output logic                        miso_oe_n,
  output flash_guard_pkg::power_mode_e power_mode,
  output logic                  [7:0] status_and_protection,
  output logic                        held,
  output logic                        op_start,
  output flash_guard_pkg::op_kind_e   op_kind,
  output logic                 [23:0] op_addr
);
  import flash_guard_pkg::*;

  generate
    if (PUW_CYC < 1 || STATUS_STORE_CMD_CYC < 1 || PP_CYC < 1 || SE_CYC < 1 || BE_CYC < 1 ||
        CNT_W < 2 || CNT_W > 31 || BE_CYC >= (1 << CNT_W) || PUW_CYC >= (1 << CNT_W) ||
        SE_CYC >= (1 << CNT_W) || PP_CYC >= (1 << CNT_W) || STATUS_STORE_CMD_CYC >= (1 << CNT_W))
    begin : g_chk
      $error("flash_guard_ctl cycle counts do not fit the counter");
    end
  endgenerate

  logic [4:0] sync_q;
  logic       sclk_s;
  logic       cs_n_s;
  logic       mosi_s;
  logic       hold_n_s;
  logic       wp_n_s;

  logic             sclk_prev_ff;
  logic             cs_prev_ff;
  logic             armed_ff;
  logic             held_ff;
  logic       [2:0] bit_cnt_ff;
  logic       [2:0] byte_cnt_ff;
  byte_t            shift_in_ff;
  byte_t            opcode_ff;
  logic      [23:0] addr_ff;
  byte_t            data_ff;
  logic             out_active_ff;
  byte_t            out_shift_ff;
  logic             miso_ff;
  logic             permit_ff;
  logic             guard_hi_ff;
  logic             guard_lo_ff;
  logic             lock_ff;
  logic             deep_ff;
  logic [CNT_W-1:0] busy_cnt_ff;
  logic [CNT_W-1:0] puw_cnt_ff;
  power_mode_e      power_mode_ff;
  logic             op_start_ff;
  op_kind_e         op_kind_ff;
  logic      [23:0] op_addr_ff;

  logic       selected;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic       byte_done;
  byte_t      nxt_byte;
  logic       busy_cycle_flag;
  logic       frame_end;
  logic       aligned;
  logic       may_modify;
  logic       hw_guard;
  logic [1:0] guard_bits;
  op_kind_e   nxt_kind;
  logic       permit_set;
  logic       permit_clr;
  logic       go_deep;
  logic       wake;

  // Reset values keep select seen low so a pin low at power-up gives no edge
  pin_sync #(
    .WIDTH   (5),
    .RST_VAL (`FLC_SYNC_RST)
  ) u_pin_sync (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .pin_in       ({wp_n_pin, hold_n_pin, mosi_pin, cs_n_pin, sclk_pin}),
    .pin_sync_out (sync_q)
  );

  assign sclk_s   = sync_q[0];
  assign cs_n_s   = sync_q[1];
  assign mosi_s   = sync_q[2];
  assign hold_n_s = sync_q[3];
  assign wp_n_s   = sync_q[4];

  function automatic logic [CNT_W-1:0] cycles_of(input op_kind_e kind);
    case (kind)
      OP_STATUS: cycles_of = CNT_W'(STATUS_STORE_CMD_CYC);
      OP_PAGE:   cycles_of = CNT_W'(PP_CYC);
      OP_SECTOR: cycles_of = CNT_W'(SE_CYC);
      OP_FULL:   cycles_of = CNT_W'(BE_CYC);
      default:   cycles_of = '0;
    endcase
  endfunction : cycles_of

  function automatic byte_t status_word(input logic busy, input logic permit,
                                        input logic lo, input logic hi, input logic lock);
    status_word                 = 8'h00;
    status_word[`FLC_ST_BUSY]   = busy;
    status_word[`FLC_ST_WEL]    = permit;
    status_word[`FLC_ST_BP0]    = lo;
    status_word[`FLC_ST_BP1]    = hi;
    status_word[`FLC_ST_LOCK]   = lock;
  endfunction : status_word

  assign selected        = armed_ff & ~cs_n_s;
  assign sclk_rise       = selected & ~held_ff & sclk_s & ~sclk_prev_ff; // (R21) (R23)
  assign sclk_fall       = selected & ~held_ff & ~sclk_s & sclk_prev_ff; // (R21) (R23)
  assign cs_rise         = cs_n_s & ~cs_prev_ff;
  assign cs_fall         = ~cs_n_s & cs_prev_ff;
  assign byte_done       = sclk_rise & (bit_cnt_ff == `FLC_BIT_LAST);
  assign nxt_byte        = {shift_in_ff[6:0], mosi_s};
  assign busy_cycle_flag = (busy_cnt_ff != '0); // (R6)
  assign guard_bits      = {guard_hi_ff, guard_lo_ff};
  assign hw_guard        = lock_ff & ~wp_n_s; // (R9)
  // Deselect while held resets the interface, so nothing executes then
  assign frame_end       = cs_rise & armed_ff & ~held_ff; // (R22)
  assign aligned         = (bit_cnt_ff == `FLC_BIT_ZERO); // (R10)
  assign may_modify      = aligned & permit_ff & (puw_cnt_ff == '0); // (R11) (R13)

  // Edge history runs even while held so no false edge shows at release
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_prev_ff <= 1'b0;
      cs_prev_ff   <= 1'b0;
    end
    else
    begin
      sclk_prev_ff <= sclk_s;
      cs_prev_ff   <= cs_n_s;
    end
  end

  // No instruction before the first select falling edge
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      armed_ff <= 1'b0;
    else if (cs_fall)
      armed_ff <= 1'b1; // (R24)
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      held_ff <= 1'b0;
    else if (!selected)
      held_ff <= 1'b0; // (R18) (R22)
    else if (!held_ff && !hold_n_s && !sclk_s)
      held_ff <= 1'b1; // (R19)
    else if (held_ff && hold_n_s && !sclk_s)
      held_ff <= 1'b0; // (R20)
  end

  // Hold freezes the counters; only deselect clears them
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt_ff  <= `FLC_BIT_ZERO;
      byte_cnt_ff <= `FLC_BIT_ZERO;
      shift_in_ff <= 8'h00;
      opcode_ff   <= 8'h00;
      addr_ff     <= 24'h00_0000;
      data_ff     <= 8'h00;
    end
    else if (!selected)
    begin
      bit_cnt_ff  <= `FLC_BIT_ZERO;
      byte_cnt_ff <= `FLC_BIT_ZERO;
    end
    else if (sclk_rise)
    begin
      shift_in_ff <= nxt_byte; // (R17) (R23)
      bit_cnt_ff  <= bit_cnt_ff + 3'h1;
      if (byte_done)
      begin
        if (byte_cnt_ff != `FLC_BYTE_MAX)
          byte_cnt_ff <= byte_cnt_ff + 3'h1;
        case (byte_cnt_ff)
          3'h0:    opcode_ff <= nxt_byte;
          3'h1:
          begin
            addr_ff[23:16] <= nxt_byte;
            data_ff        <= nxt_byte;
          end
          3'h2:    addr_ff[15:8] <= nxt_byte;
          3'h3:    addr_ff[7:0]  <= nxt_byte;
          default: ;
        endcase
      end
    end
  end

  // Execution decode at the end of a frame
  always_comb
  begin
    nxt_kind   = OP_NONE;
    permit_set = 1'b0;
    permit_clr = 1'b0;
    go_deep    = 1'b0;
    wake       = 1'b0;
    if (frame_end)
    begin
      if (deep_ff)
      begin
        if (opcode_ff == `FLC_OP_RES)
          wake = 1'b1; // (R4) (R5)
      end
      else if (!busy_cycle_flag)
      begin
        case (opcode_ff)
          `FLC_OP_MODIFY_PERMIT_SET_CMD:
            if (aligned && byte_cnt_ff == `FLC_LEN_ONE)
              permit_set = 1'b1;
          `FLC_OP_MODIFY_PERMIT_CLEAR_CMD:
            if (aligned && byte_cnt_ff == `FLC_LEN_ONE)
              permit_clr = 1'b1; // (R12)
          `FLC_OP_DP:
            if (aligned && byte_cnt_ff == `FLC_LEN_ONE)
              go_deep = 1'b1; // (R3)
          `FLC_OP_STATUS_STORE_CMD:
            if (may_modify && byte_cnt_ff >= `FLC_LEN_STATUS_STORE_CMD && !hw_guard)
              nxt_kind = OP_STATUS; // (R9) (R10) (R11)
          `FLC_OP_PP:
            if (may_modify && byte_cnt_ff >= `FLC_LEN_PP && guard_bits != `FLC_BP_ALL)
              nxt_kind = OP_PAGE; // (R14) (R15)
          `FLC_OP_SE:
            if (may_modify && byte_cnt_ff == `FLC_LEN_SE && guard_bits != `FLC_BP_ALL)
              nxt_kind = OP_SECTOR; // (R14) (R15)
          `FLC_OP_BE:
            if (may_modify && byte_cnt_ff == `FLC_LEN_ONE && guard_bits == `FLC_BP_NONE)
              nxt_kind = OP_FULL; // (R16)
          default: ;
        endcase
      end
    end
  end

  // Cycles run to completion regardless of hold or select
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_cnt_ff <= '0;
    else if (nxt_kind != OP_NONE)
      busy_cnt_ff <= cycles_of(nxt_kind); // (R6)
    else if (busy_cycle_flag)
      busy_cnt_ff <= busy_cnt_ff - CNT_W'(1); // (R17)
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      puw_cnt_ff <= CNT_W'(PUW_CYC); // (R13)
    else if (puw_cnt_ff != '0)
      puw_cnt_ff <= puw_cnt_ff - CNT_W'(1); // (R13)
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      permit_ff <= 1'b0; // (R12)
    else if (permit_clr || nxt_kind != OP_NONE)
      permit_ff <= 1'b0; // (R12)
    else if (permit_set)
      permit_ff <= 1'b1; // (R11)
  end

  // Non-volatile bits modelled by flops reset to the delivery state
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      guard_hi_ff <= 1'(`FLC_NV_BP_RST >> 1);
      guard_lo_ff <= 1'(`FLC_NV_BP_RST);
      lock_ff     <= `FLC_NV_LOCK_RST;
    end
    else if (nxt_kind == OP_STATUS)
    begin
      guard_hi_ff <= data_ff[`FLC_ST_BP1]; // (R8)
      guard_lo_ff <= data_ff[`FLC_ST_BP0]; // (R8)
      lock_ff     <= data_ff[`FLC_ST_LOCK];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      deep_ff <= 1'b0;
    else if (go_deep)
      deep_ff <= 1'b1; // (R3)
    else if (wake)
      deep_ff <= 1'b0; // (R4)
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      power_mode_ff <= PWR_STANDBY;
    else if (deep_ff)
      power_mode_ff <= PWR_DEEP;
    // Accepted op counts too, else a one-cycle standby gap shows before busy
    else if (selected || busy_cycle_flag || nxt_kind != OP_NONE)
      power_mode_ff <= PWR_ACTIVE; // (R1) (R2)
    else
      power_mode_ff <= PWR_STANDBY; // (R2)
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_start_ff <= 1'b0;
      op_kind_ff  <= OP_NONE;
      op_addr_ff  <= 24'h00_0000;
    end
    else
    begin
      op_start_ff <= (nxt_kind != OP_NONE);
      if (nxt_kind != OP_NONE)
      begin
        op_kind_ff <= nxt_kind;
        op_addr_ff <= addr_ff;
      end
    end
  end

  // Output byte reloaded at each byte boundary so polling sees fresh status
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_active_ff <= 1'b0;
      out_shift_ff  <= 8'h00;
      miso_ff       <= 1'b0;
    end
    else if (!selected)
      out_active_ff <= 1'b0;
    else if (byte_done)
    begin
      if (byte_cnt_ff == `FLC_BIT_ZERO && nxt_byte == `FLC_OP_RDSR && !deep_ff)
      begin
        out_active_ff <= 1'b1;
        out_shift_ff  <= status_word(busy_cycle_flag, permit_ff, guard_lo_ff,
                                     guard_hi_ff, lock_ff); // (R7)
      end
      else if (byte_cnt_ff != `FLC_BIT_ZERO && opcode_ff == `FLC_OP_RDSR && out_active_ff)
        out_shift_ff <= status_word(busy_cycle_flag, permit_ff, guard_lo_ff,
                                    guard_hi_ff, lock_ff);
      else if (opcode_ff == `FLC_OP_RES && byte_cnt_ff >= `FLC_RES_DUMMY_LAST)
      begin
        out_active_ff <= 1'b1;
        out_shift_ff  <= `FLC_SIGNATURE;
      end
    end
    else if (sclk_fall && out_active_ff)
    begin
      miso_ff      <= out_shift_ff[7]; // (R23)
      out_shift_ff <= {out_shift_ff[6:0], 1'b0};
    end
  end

  assign miso                  = miso_ff;
  assign miso_oe_n             = ~(out_active_ff & selected & ~held_ff); // (R21)
  assign power_mode            = power_mode_ff;
  assign status_and_protection = status_word(busy_cycle_flag, permit_ff, guard_lo_ff,
                                             guard_hi_ff, lock_ff); // (R6) (R7)
  assign held                  = held_ff;
  assign op_start              = op_start_ff;
  assign op_kind               = op_kind_ff;
  assign op_addr               = op_addr_ff;
endmodule : flash_guard_ctl

// file: test/flash_guard_ctl_assertions.sv
// Port assertions for the serial flash guard block
`timescale 1ns/1ns
module flash_guard_ctl_checker
  import flash_guard_pkg::*;
(
  input wire logic                         core_clk,
  input wire logic                         reset_n,
  input wire logic                         cs_n_pin,
  input wire logic                         hold_n_pin,
  input wire logic                         miso_oe_n,
  input wire flash_guard_pkg::power_mode_e power_mode,
  input wire logic                   [7:0] status_and_protection,
  input wire logic                         held,
  input wire logic                         op_start
);
  wire logic busy = status_and_protection[0];
  wire logic permit = status_and_protection[1];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  busy_on_start_a: assert property (op_start |-> busy)
    else $error("busy flag missing at accepted operation");
  permit_cleared_a: assert property (op_start |-> !permit)
    else $error("permit latch still set at accepted operation");
  busy_active_a: assert property (busy |-> power_mode == PWR_ACTIVE)
    else $error("not active during internal cycle");
  select_active_a: assert property (
    (!cs_n_pin) [*5] ##0 (power_mode != PWR_DEEP) |-> power_mode == PWR_ACTIVE)
    else $error("selected but not active");
  idle_standby_a: assert property (
    (cs_n_pin && !busy && power_mode != PWR_DEEP) [*6] |-> power_mode == PWR_STANDBY)
    else $error("idle and deselected but not in standby");
  deep_stays_a: assert property (
    cs_n_pin [*8] ##0 (power_mode == PWR_DEEP) |=> power_mode == PWR_DEEP)
    else $error("deep power-down left without a frame");
  deep_entry_a: assert property (
    power_mode == PWR_DEEP && $past(power_mode) != PWR_DEEP |-> cs_n_pin && !busy)
    else $error("deep power-down entered outside a frame end");
  deep_no_op_a: assert property (power_mode == PWR_DEEP |-> !op_start)
    else $error("operation started in deep power-down");
  held_float_a: assert property (held |-> miso_oe_n)
    else $error("output driven while held");
  hold_entry_a: assert property (
    $rose(held) |-> !$past(hold_n_pin, 2) && !$past(cs_n_pin, 2))
    else $error("hold entered without hold request while selected");
  hold_exit_a: assert property (
    $fell(held) |-> $past(hold_n_pin, 2) || $past(cs_n_pin, 2))
    else $error("hold left without release or deselect");
  start_at_end_a: assert property (op_start |-> cs_n_pin && $past(cs_n_pin, 2))
    else $error("operation started before frame end");
endmodule : flash_guard_ctl_checker

bind flash_guard_ctl flash_guard_ctl_checker flash_guard_ctl_checker_inst (
  .core_clk              (core_clk),
  .reset_n               (reset_n),
  .cs_n_pin              (cs_n_pin),
  .hold_n_pin            (hold_n_pin),
  .miso_oe_n             (miso_oe_n),
  .power_mode            (power_mode),
  .status_and_protection (status_and_protection),
  .held                  (held),
  .op_start              (op_start)
);

// file: test/spi_master_model.sv
// Serial bus master model facing the flash guard block
`timescale 1ns/1ns
module spi_master_model (
  input  wire logic core_clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  output logic      hold_n
);
  logic [63:0] rx;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    hold_n = 1'b1;
    rx = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // MSB first; hold_at below zero means no pause, drop deselects while held
  task automatic frame(input logic [63:0] data, input int nbits, input int hold_at,
                       input bit drop);
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < nbits; i++)
    begin
      if (i == hold_at)
      begin
        hold_n = 1'b0;
        tick(6);
        // Stray clock and data while paused
        sclk = 1'b1;
        mosi = ~mosi;
        tick(4);
        sclk = 1'b0;
        tick(4);
        if (drop)
        begin
          cs_n = 1'b1;
          tick(6);
          hold_n = 1'b1;
          tick(6);
          return;
        end
        hold_n = 1'b1;
        tick(6);
      end
      mosi = data[63 - i];
      tick(4);
      rx = {rx[62:0], miso};
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    mosi = ~mosi;
    tick(6);
  endtask : frame
endmodule : spi_master_model

// file: test/flash_guard_ctl_test.sv
// Self-checking bench for the serial flash guard block
`timescale 1ns/1ns
`include "flash_guard_map.svh"
module flash_guard_ctl_test;
  import flash_guard_pkg::*;
  typedef struct {logic en; logic [39:0] d; int n; logic wp; logic st; op_kind_e k;
                  logic [7:0] g;} row_s;
  localparam logic [63:0] EN = 64'h0600_0000_0000_0000;
  localparam logic [63:0] DIS = 64'h0400_0000_0000_0000;
  localparam logic [63:0] SE = 64'hd801_2345_0000_0000;
  localparam int PUW_T = 400;
  localparam int STATUS_STORE_CMD_T = 12;
  localparam int PP_T = 16;
  localparam int SE_T = 20;
  localparam int BE_T = 24;
  logic        core_clk, reset_n, wp_n, sclk, cs_n, mosi, hold_n;
  logic        miso, miso_oe_n, held, op_start;
  wire         miso_line = miso_oe_n ? 1'bz : miso;
  power_mode_e power_mode;
  op_kind_e    op_kind;
  logic  [7:0] status_and_protection;
  logic [23:0] op_addr;
  int          fail_count, comparisons, starts, busy_cyc, held_cyc;
  int          cyc[5] = '{0, STATUS_STORE_CMD_T, PP_T, SE_T, BE_T};
  row_s rows[18] = '{
    '{1'b1, 40'h0100_0000_00, 16, 1'b1, 1'b1, OP_STATUS, 8'h00},
    '{1'b0, 40'hd801_2345_00, 32, 1'b1, 1'b0, OP_NONE, 8'h00},
    '{1'b1, 40'hd801_2345_00, 33, 1'b1, 1'b0, OP_NONE, 8'h00},
    '{1'b1, 40'hd801_2345_00, 32, 1'b1, 1'b1, OP_SECTOR, 8'h00},
    '{1'b1, 40'h0201_2345_a5, 40, 1'b1, 1'b1, OP_PAGE, 8'h00},
    '{1'b1, 40'hc700_0000_00, 8, 1'b1, 1'b1, OP_FULL, 8'h00},
    '{1'b1, 40'h0104_0000_00, 16, 1'b1, 1'b1, OP_STATUS, 8'h04},
    '{1'b1, 40'hc700_0000_00, 8, 1'b1, 1'b0, OP_NONE, 8'h04},
    '{1'b1, 40'hd801_2345_00, 32, 1'b1, 1'b1, OP_SECTOR, 8'h04},
    '{1'b1, 40'h0108_0000_00, 16, 1'b1, 1'b1, OP_STATUS, 8'h08},
    '{1'b1, 40'hc700_0000_00, 8, 1'b1, 1'b0, OP_NONE, 8'h08},
    '{1'b1, 40'h010c_0000_00, 16, 1'b1, 1'b1, OP_STATUS, 8'h0c},
    '{1'b1, 40'h0201_2345_a5, 40, 1'b1, 1'b0, OP_NONE, 8'h0c},
    '{1'b1, 40'hd801_2345_00, 32, 1'b1, 1'b0, OP_NONE, 8'h0c},
    '{1'b1, 40'h0180_0000_00, 16, 1'b1, 1'b1, OP_STATUS, 8'h80},
    '{1'b1, 40'h0100_0000_00, 16, 1'b0, 1'b0, OP_NONE, 8'h80},
    '{1'b1, 40'h0100_0000_00, 16, 1'b1, 1'b1, OP_STATUS, 8'h00},
    '{1'b1, 40'h0400_0000_00, 8, 1'b1, 1'b0, OP_NONE, 8'h00}};

  flash_guard_ctl #(.PUW_CYC(PUW_T), .STATUS_STORE_CMD_CYC(STATUS_STORE_CMD_T), .PP_CYC(PP_T), .SE_CYC(SE_T),
    .BE_CYC(BE_T))
    flash_guard_ctl_inst (.core_clk(core_clk), .reset_n(reset_n), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .mosi_pin(mosi), .hold_n_pin(hold_n), .wp_n_pin(wp_n),
    .miso(miso), .miso_oe_n(miso_oe_n), .power_mode(power_mode),
    .status_and_protection(status_and_protection), .held(held), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr));

  spi_master_model master_inst (.core_clk(core_clk), .miso(miso_line), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge core_clk)
  begin
    starts += int'(op_start === 1'b1);
    busy_cyc += int'(status_and_protection[0] === 1'b1);
    held_cyc += int'(held === 1'b1);
  end

  task automatic give_verdict;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Bounded wait for the internal cycle to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (status_and_protection[0] !== 1'b0 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 300)
    begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_idle

  task automatic do_reset;
    reset_n = 1'b0;
    master_inst.tick(4);
    reset_n = 1'b1;
  endtask : do_reset

  initial
  begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    fail_count = 0;
    comparisons = 0;
    starts = 0;
    busy_cyc = 0;
    held_cyc = 0;
    do_reset();
    master_inst.tick(400);
    foreach (rows[i])
    begin
      wp_n = rows[i].wp;
      if (rows[i].en)
        master_inst.frame(EN, 8, -1, 1'b0);
      starts = 0;
      busy_cyc = 0;
      master_inst.frame({rows[i].d, 24'h00_0000}, rows[i].n, -1, 1'b0);
      wait_idle();
      check(starts, 32'(rows[i].st));
      check(busy_cyc, rows[i].st ? cyc[rows[i].k] : 0);
      if (rows[i].st)
        check(op_kind, rows[i].k);
      check(status_and_protection, rows[i].g | {6'h00, rows[i].en & ~rows[i].st &
        (rows[i].d[39:32] != 8'h04), 1'b0});
    end
    // Status read and deep power-down
    master_inst.frame(EN, 8, -1, 1'b0);
    master_inst.frame(64'h0500_0000_0000_0000, 16, -1, 1'b0);
    check(master_inst.rx[7:0], 8'h02);
    master_inst.frame(64'hb900_0000_0000_0000, 8, -1, 1'b0);
    check(power_mode, PWR_DEEP);
    starts = 0;
    master_inst.frame(EN, 8, -1, 1'b0);
    master_inst.frame(SE, 32, -1, 1'b0);
    check(starts, 0);
    check(power_mode, PWR_DEEP);
    master_inst.frame(64'hab00_0000_0000_0000, 40, -1, 1'b0);
    check(master_inst.rx[7:0], `FLC_SIGNATURE);
    check(power_mode, PWR_STANDBY);
    // Pause mid-frame, then deselect while paused
    master_inst.frame(DIS, 8, -1, 1'b0);
    held_cyc = 0;
    master_inst.frame(EN, 8, 3, 1'b0);
    check(held_cyc > 4, 1'b1);
    check(status_and_protection[1], 1'b1);
    master_inst.frame(DIS, 8, -1, 1'b0);
    master_inst.frame(EN, 8, 3, 1'b1);
    check(status_and_protection[1], 1'b0);
    check(held, 1'b0);
    master_inst.frame(EN, 8, -1, 1'b0);
    check(status_and_protection[1], 1'b1);
    // Second reset: values, then the power-up delay
    do_reset();
    check(status_and_protection, 8'h00);
    check(power_mode, PWR_STANDBY);
    master_inst.tick(4);
    starts = 0;
    master_inst.frame(EN, 8, -1, 1'b0);
    master_inst.frame(SE, 32, -1, 1'b0);
    check(starts, 0);
    master_inst.tick(400);
    master_inst.frame(EN, 8, -1, 1'b0);
    master_inst.frame(SE, 32, -1, 1'b0);
    check(starts, 1);
    check(op_addr, 24'h0123_45);
    wait_idle();
    give_verdict();
  end
endmodule : flash_guard_ctl_test
